// ===== verilog/mdr_pkg.sv
// Package for the multichannel converter refresh controller.
// Assumes a 10 MHz system clock; all offsets are 16-bit word byte addresses.
package mdr_pkg;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          NUM_CH         = 16;
  localparam int          CODE_W         = 12;
  localparam int          WORD_W         = 16;
  localparam int          ADDR_W         = 6;
  // Register byte offsets
  localparam logic [5:0]  OFF_ID         = 6'h00;
  localparam logic [5:0]  OFF_CTRL       = 6'h02;
  localparam logic [5:0]  OFF_CH_BASE    = 6'h20;
  // Identification word; value is arbitrary
  localparam logic [15:0] ID_VALUE       = 16'hA5C0;
  // Control word field positions
  localparam int          BIT_FAST       = 8;
  localparam int          BIT_HALT       = 9;
  localparam int          BIT_CUR_ON     = 10;
  localparam int          BIT_VOLT_ON    = 11;
  localparam int          BIT_UNSIGNED   = 12;
  localparam int          BIT_FAIL_N     = 14;
  localparam logic [15:0] CTRL_MASK      = 16'h5F00;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // Refresh cycle times in microseconds (longest, so round down)
  localparam int          CYCLE_SLOW_US  = 1700;
  localparam int          CYCLE_FAST_US  = 600;
  localparam int          SETTLE_US      = 100;
  localparam int          SLOT_SLOW_CYC  =
    (CLK_HZ / 1_000_000) * CYCLE_SLOW_US / NUM_CH;
  localparam int          SLOT_FAST_CYC  =
    (CLK_HZ / 1_000_000) * CYCLE_FAST_US / NUM_CH;
  localparam int          SETTLE_CYC     = 
    (CLK_HZ / 1_000_000) * SETTLE_US * CYCLE_FAST_US / CYCLE_SLOW_US / 4;
  localparam int          LOAD_CYC       = 2;
  localparam int          CNT_W          = 11;
endpackage

// ===== verilog/mdr_code_ram.sv
// Sixteen-word code store: host write port, two read ports.
// Assumes one clock; writes take effect at the next edge.
`timescale 1ns/100ps
module mdr_code_ram #(
  parameter int DEPTH = 16,
  parameter int W     = 12
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_a_idx,
  output      logic [W-1:0]             rd_a_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_b_idx,
  output      logic [W-1:0]             rd_b_data
);
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en)
      mem_q[wr_idx] <= wr_data;
  end

  assign rd_a_data = mem_q[rd_a_idx];
  assign rd_b_data = mem_q[rd_b_idx];
endmodule

// ===== verilog/mdr_refresh_ctrl.sv
// Refresh controller: host word registers, control word, DAC sequencer.
// Assumes a synchronous host strobe interface and a 10 MHz clock.
//
// Contract
// - Channel registers hold a 12-bit code in bits 11..0.
// - Writes to channel bits 15..12 are dropped and never read back.
// - A newly written code reaches the converter within one cycle time.
// - Unsigned coding passes code 000..FFF straight to the converter.
// - Signed coding treats the code as two's complement 800..7FF.
// - Fast-rate bit shortens the whole refresh cycle to 0.6 ms.
// - Voltage-online bit enables all voltage-output channels.
// - Current channels enable only when both online bits are set.
// - Voltage-online low places voltage outputs in high impedance.
// - Current-online low holds current channels at range minimum.
// - Halt bit stops sequencer advance and updates until cleared.
// - One bus privilege class only; host must use that class.
// - Control bit 12 high selects unsigned, low two's complement.
// - Reset clears every control bit to zero.
// - Control bit 8 selects 1.7 ms (0) or 0.6 ms (1) interval.
// - Bit 11 is voltage-online, bit 10 current-online.
`timescale 1ns/100ps
module mdr_refresh_ctrl #(
  parameter int NUM_CH    = mdr_pkg::NUM_CH,
  parameter int SLOT_SLOW = mdr_pkg::SLOT_SLOW_CYC,
  parameter int SLOT_FAST = mdr_pkg::SLOT_FAST_CYC,
  parameter int SETTLE    = mdr_pkg::SETTLE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        bus_sel,
  input  wire logic        bus_priv,
  input  wire logic        priv_cfg,
  input  wire logic        bus_wr,
  input  wire logic [5:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  output      logic [15:0] bus_rdata,
  output      logic        bus_ack,
  output      logic [11:0] dac_code,
  output      logic        dac_load,
  output      logic [3:0]  demux_sel,
  output      logic        demux_en,
  output      logic        volt_out_en,
  output      logic        cur_out_en,
  output      logic        cur_force_min,
  output      logic        fail_led_n
);
  typedef enum logic [1:0] {MDR_LOAD, MDR_SETTLE, MDR_WAIT} mdr_state_t;

  logic [15:0]       ctrl_q;
  logic [3:0]        chan_q;
  logic [10:0]       cnt_q;
  mdr_state_t        st_q;
  logic [11:0]       rd_host;
  logic [11:0]       rd_seq;
  logic              acc;
  logic              ch_hit;
  logic [3:0]        ch_idx;
  logic [10:0]       slot_len;

  function automatic logic [11:0] dac_map(input logic [11:0] c,
                                          input logic        uns);
    dac_map = uns ? c : {~c[11], c[10:0]};
  endfunction

  // Only the configured privilege class is answered
  assign acc    = bus_sel && (bus_priv == priv_cfg);
  assign ch_hit = bus_addr[5] == mdr_pkg::OFF_CH_BASE[5];
  assign ch_idx = bus_addr[4:1];
  assign slot_len = ctrl_q[mdr_pkg::BIT_FAST] ? 11'(SLOT_FAST)
                                              : 11'(SLOT_SLOW);

  mdr_code_ram #(
    .DEPTH (NUM_CH),
    .W     (mdr_pkg::CODE_W)
  ) u_ram (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .wr_en     (acc && bus_wr && ch_hit),
    .wr_idx    (ch_idx),
    .wr_data   (bus_wdata[11:0]),
    .rd_a_idx  (ch_idx),
    .rd_a_data (rd_host),
    .rd_b_idx  (chan_q),
    .rd_b_data (rd_seq)
  );

  // Control word
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_q <= mdr_pkg::CTRL_RESET;
    else if (acc && bus_wr && bus_addr == mdr_pkg::OFF_CTRL)
      ctrl_q <= bus_wdata & mdr_pkg::CTRL_MASK;
  end

  // Host read data and acknowledge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_rdata <= 16'h0000;
      bus_ack   <= 1'b0;
    end
    else
    begin
      bus_ack <= acc;
      if (acc && !bus_wr)
      begin
        if (ch_hit)
          bus_rdata <= {4'h0, rd_host};
        else if (bus_addr == mdr_pkg::OFF_CTRL)
          bus_rdata <= ctrl_q;
        else if (bus_addr == mdr_pkg::OFF_ID)
          bus_rdata <= mdr_pkg::ID_VALUE;
        else
          bus_rdata <= 16'h0000;
      end
    end
  end

  // Refresh sequencer: load, settle with demux on, wait out the slot
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q      <= MDR_LOAD;
      chan_q    <= 4'h0;
      cnt_q     <= 11'h000;
      dac_code  <= 12'h000;
      dac_load  <= 1'b0;
      demux_sel <= 4'h0;
      demux_en  <= 1'b0;
    end
    else if (ctrl_q[mdr_pkg::BIT_HALT])
    begin
      dac_load <= 1'b0;
      demux_en <= 1'b0;
    end
    else
    begin
      dac_load <= 1'b0;
      cnt_q    <= cnt_q + 11'h001;
      unique case (st_q)
        MDR_LOAD:
        begin
          dac_code  <= dac_map(rd_seq, ctrl_q[mdr_pkg::BIT_UNSIGNED]);
          dac_load  <= 1'b1;
          demux_sel <= chan_q;
          cnt_q     <= 11'h000;
          st_q      <= MDR_SETTLE;
        end
        MDR_SETTLE:
        begin
          demux_en <= 1'b1;
          if (cnt_q >= 11'(SETTLE))
          begin
            demux_en <= 1'b0;
            st_q     <= MDR_WAIT;
          end
        end
        MDR_WAIT:
        begin
          if (cnt_q >= slot_len - 11'h002)
          begin
            chan_q <= chan_q + 4'h1;
            st_q   <= MDR_LOAD;
          end
        end
      endcase
    end
  end

  // Output enables
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      volt_out_en   <= 1'b0;
      cur_out_en    <= 1'b0;
      cur_force_min <= 1'b1;
      fail_led_n    <= 1'b0;
    end
    else
    begin
      volt_out_en   <= ctrl_q[mdr_pkg::BIT_VOLT_ON];
      cur_out_en    <= ctrl_q[mdr_pkg::BIT_VOLT_ON]
                       && ctrl_q[mdr_pkg::BIT_CUR_ON];
      cur_force_min <= !ctrl_q[mdr_pkg::BIT_CUR_ON];
      fail_led_n    <= ctrl_q[mdr_pkg::BIT_FAIL_N];
    end
  end

  // Cycles since the last converter load or halted cycle; a slot is far too long for a
  // delay range at the default rate, so the gap is counted instead
  logic [10:0]       gap_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gap_q <= 11'h000;
    else if (dac_load || ctrl_q[mdr_pkg::BIT_HALT])
      gap_q <= 11'h000;
    else
      gap_q <= gap_q + 11'h001;
  end

  a_halt_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_q[mdr_pkg::BIT_HALT] |=> !dac_load)
    else $error("load while halted");
  a_halt_chan: assert property (@(posedge clk_sys) disable iff (rst)
    $past(ctrl_q[mdr_pkg::BIT_HALT]) |-> $stable(chan_q))
    else $error("channel moved while halted");
  a_cur_enable: assert property (@(posedge clk_sys) disable iff (rst)
    cur_out_en |-> volt_out_en)
    else $error("current on without voltage");
  a_volt_follow: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 volt_out_en == $past(ctrl_q[mdr_pkg::BIT_VOLT_ON]))
    else $error("voltage enable mismatch");
  a_cur_min: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_q[mdr_pkg::BIT_CUR_ON] |=> cur_force_min && !cur_out_en)
    else $error("current not held at min");
  a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_q & ~mdr_pkg::CTRL_MASK) == 16'h0000)
    else $error("reserved control bit set");
  a_read_upper: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(bus_ack) && !$past(bus_wr) && $past(ch_hit)
      |-> bus_rdata[15:12] == 4'h0)
    else $error("channel read upper bits");
  a_load_code: assert property (@(posedge clk_sys) disable iff (rst)
    dac_load && !$past(ctrl_q[mdr_pkg::BIT_UNSIGNED])
      |-> dac_code[11] != $past(rd_seq[11]))
    else $error("signed MSB not inverted");
  sequence s_load_next;
    dac_load ##1 !dac_load [*2];
  endsequence
  a_load_spacing: assert property (@(posedge clk_sys) disable iff (rst)
    dac_load |-> s_load_next)
    else $error("loads too close");
  a_refresh_bound: assert property (@(posedge clk_sys) disable iff (rst)
    gap_q < 11'(SLOT_SLOW))
    else $error("slot too long");
endmodule

// ===== test/mdr_host_model.sv
// Host model: register accesses on the strobe bus.
// Assumes a registered acknowledge; each request is held until it is seen or four edges pass.
`timescale 1ns/100ps
module mdr_host_model (
  input  wire logic        clk_sys,
  output      logic        bus_sel,
  output      logic        bus_priv,
  output      logic        bus_wr,
  output      logic [5:0]  bus_addr,
  output      logic [15:0] bus_wdata,
  input  wire logic [15:0] bus_rdata,
  input  wire logic        bus_ack
);
  initial
  begin
    bus_sel   = 1'b0;
    bus_priv  = 1'b1;
    bus_wr    = 1'b0;
    bus_addr  = 6'h3F;
    bus_wdata = 16'h5A5A;
  end
  // Idle address and data lines are inverted so that a stale value never matches
  task automatic xfer(input logic wr, input logic [5:0] addr,
                      input logic [15:0] data, input logic priv,
                      output logic [15:0] rdata, output logic ack);
    int wt;
    wt    = 0;
    ack   = 1'b0;
    rdata = 16'h0000;
    @(posedge clk_sys);
    #1;
    bus_sel   = 1'b1;
    bus_wr    = wr;
    bus_addr  = addr;
    bus_wdata = data;
    bus_priv  = priv;
    // Request stands until the acknowledge is sampled high at an edge;
    // a refused class never answers, so the wait is bounded
    do
    begin
      @(posedge clk_sys);
      wt++;
    end
    while (bus_ack !== 1'b1 && wt < 4);
    rdata = bus_rdata;
    ack   = bus_ack;
    #1;
    bus_sel   = 1'b0;
    bus_priv  = 1'b1;
    bus_addr  = ~addr;
    bus_wdata = ~data;
  endtask
endmodule

// ===== test/test_mdr_refresh_ctrl.sv
// Bench for the refresh controller: register traffic and sequencer checks.
// Assumes short sim slots of 40 slow, 20 fast and a settle of 4 cycles.
`timescale 1ns/100ps
module test_mdr_refresh_ctrl;
  logic        clk_sys, rst, priv_cfg, ak, bus_sel, bus_priv, bus_wr;
  logic        bus_ack, dac_load, demux_en, volt_out_en, cur_out_en;
  logic        cur_force_min, fail_led_n;
  logic [5:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rd;
  logic [11:0] dac_code;
  logic [3:0]  demux_sel;
  int          fails, tests_run, n, k;
  logic [15:0] ctl_v [4] = '{16'h0800, 16'h0C00, 16'h0400, 16'h4000};
  logic [15:0] out_v [4] = '{16'h0005, 16'h0006, 16'h0000, 16'h0009};

  mdr_refresh_ctrl #(.SLOT_SLOW(40), .SLOT_FAST(20), .SETTLE(4)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .bus_sel(bus_sel), .bus_priv(bus_priv),
    .priv_cfg(priv_cfg), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .dac_code(dac_code), .dac_load(dac_load), .demux_sel(demux_sel),
    .demux_en(demux_en), .volt_out_en(volt_out_en),
    .cur_out_en(cur_out_en), .cur_force_min(cur_force_min),
    .fail_led_n(fail_led_n));
  mdr_host_model host_u (
    .clk_sys(clk_sys), .bus_sel(bus_sel), .bus_priv(bus_priv),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host_u.xfer(1'b1, a, d, 1'b1, rd, ak);
    chk({15'h0, ak}, 16'h0001);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    host_u.xfer(1'b0, a, 16'h0000, 1'b1, rd, ak);
    chk(rd, e);
  endtask
  // Waits for the converter load of one channel; cyc is the wait length
  task automatic wait_load(input logic [3:0] ch, output int cyc);
    cyc = 0;
    do
    begin
      @(negedge clk_sys);
      cyc++;
    end
    while (!(dac_load === 1'b1 && demux_sel === ch) && cyc < 3000);
    if (cyc >= 3000)
      chk(16'hDEAD, 16'h0000);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    close_out();
  end

  initial
  begin
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    priv_cfg = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk({15'h0, cur_force_min}, 16'h0001);
    rdc(6'h02, 16'h0000);
    rdc(6'h04, 16'h0000);
    $display("test reset done");
    wr(6'h20, 16'h1ABC);
    rdc(6'h20, 16'h0ABC);
    wr(6'h02, 16'h1000);
    wait_load(4'h0, n);
    chk({4'h0, dac_code}, 16'h0ABC);
    chk({15'h0, n <= 16 * 40 + 4}, 16'h0001);
    $display("test unsigned done");
    wr(6'h26, 16'h0800);
    wr(6'h02, 16'h0000);
    wait_load(4'h3, n);
    chk({4'h0, dac_code}, 16'h0000);
    wait_load(4'h0, n);
    chk({4'h0, dac_code}, 16'h02BC);
    @(negedge clk_sys);
    chk({15'h0, demux_en}, 16'h0001);
    $display("test signed done");
    wait_load(4'h4, n);
    wait_load(4'h5, n);
    chk(n[15:0], 16'd40);
    wr(6'h02, 16'h0100);
    wait_load(4'h6, n);
    wait_load(4'h7, n);
    chk(n[15:0], 16'd20);
    $display("test rate done");
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h02, ctl_v[i]);
      repeat (2) @(negedge clk_sys);
      chk({12'h0, fail_led_n, volt_out_en, cur_out_en, cur_force_min},
          out_v[i]);
    end
    $display("test online done");
    wr(6'h02, 16'h0200);
    k = 0;
    repeat (100)
    begin
      @(negedge clk_sys);
      if (dac_load !== 1'b0 || demux_en !== 1'b0)
        k++;
    end
    chk(k[15:0], 16'h0000);
    wr(6'h02, 16'h0000);
    $display("test halt done");
    host_u.xfer(1'b1, 6'h22, 16'h0123, 1'b0, rd, ak);
    chk({15'h0, ak}, 16'h0000);
    rdc(6'h22, 16'h0000);
    $display("test privilege done");
    close_out();
  end
endmodule
